// ### qvsc_pkg.sv
// constants shared by the four-channel volume serial control block
// assumes a 40 MHz system clock; the serial pins arrive asynchronously
package qvsc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ        = 40000;               // clk_sys rate, kHz
    localparam int PWR_RST_MS     = 100;                 // power-up reset interval
    localparam int ZC_TMO_MS      = 16;                  // zero-cross wait limit
    localparam int CAL_TIME_US    = 1000;                // offset calibration length
    localparam int PWR_RST_CYC    = PWR_RST_MS * CLK_KHZ;
    localparam int ZC_TMO_CYC     = ZC_TMO_MS * CLK_KHZ;
    localparam int CAL_CYC        = (CAL_TIME_US * CLK_KHZ) / 1000;
    localparam int SEQ_CNT_W      = 23;                  // holds the 100 ms count
    localparam int TMO_CNT_W      = 20;                  // holds the 16 ms count

    // ------------------------------------------------------------
    // frame layout: channel four first on the wire, channel one last
    // ------------------------------------------------------------
    localparam int NUM_CH         = 4;
    localparam int FIELD_W        = 8;
    localparam int FRAME_W        = NUM_CH * FIELD_W;    // 32-bit word
    localparam int CH_LSB [NUM_CH] = '{0, 8, 16, 24};    // ch1 .. ch4

    // ------------------------------------------------------------
    // gain decode and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GAIN_MUTE_CODE = 8'h00;       // software mute
    localparam logic [8:0] GAIN_CODE_OFS  = 9'h0c0;      // code 192 = 0 dB
    localparam logic [8:0] GAIN_UNITY_HDB = 9'h000;      // unity gain, half-dB

    // sequencer states
    typedef enum logic [1:0] {
        ST_PWR,
        ST_CAL,
        ST_RUN,
        ST_UV
    } qvsc_state_type;

endpackage

// ### qvsc_channel.sv
// one channel: holds the programmed gain and applies it, and the hardware mute,
// at a zero crossing or after a timeout
// assumes zc_pulse is a one-cycle clk_sys pulse on a positive-slope crossing
`timescale 1ns/1ps

module qvsc_channel
    import qvsc_pkg::*;
#(
    parameter int TMO_CYC = ZC_TMO_CYC,
    parameter int CW      = TMO_CNT_W
) (
    input  wire logic        clk_sys,      // system clock
    input  wire logic        arst_n,       // async reset, low
    input  wire logic        clear,        // power sequence: zero gain, mute now
    input  wire logic        load,         // new frame field present
    input  wire logic [7:0]  new_code,     // field from the frame
    input  wire logic        zc_gate_en,   // gate gain changes on crossings
    input  wire logic        zc_pulse,     // positive-slope crossing seen
    input  wire logic        mute_req,     // hardware mute requested
    output logic [7:0]       gain_code,    // applied gain code
    output logic signed [8:0] gain_hdb,    // applied gain, half-dB steps
    output logic             in_grounded,  // amp input on analog ground
    output logic             out_off       // outputs disconnected, terminated
);

    logic [7:0]    target;
    logic          gain_pend;
    logic [CW-1:0] gain_tmr;
    logic [CW-1:0] mute_tmr;

    // ------------------------------------------------------------
    // decode and gating terms
    // ------------------------------------------------------------
    wire         changed   = load && (new_code != target);
    wire         gain_tout = (gain_tmr == CW'(TMO_CYC - 1));
    wire         gain_go   = gain_pend && (!zc_gate_en || zc_pulse || gain_tout);
    wire         mute_diff = (mute_req != out_off);
    wire         mute_tout = (mute_tmr == CW'(TMO_CYC - 1));
    wire         mute_go   = mute_diff && (zc_pulse || mute_tout);
    wire [7:0]   apply_val = changed && !zc_gate_en ? new_code : target;
    wire         apply_now = (changed && !zc_gate_en) || gain_go;
    wire [8:0]   dec_hdb   = (apply_val == GAIN_MUTE_CODE) ? GAIN_UNITY_HDB
                                                           : ({1'b0, apply_val} - GAIN_CODE_OFS);

    // ------------------------------------------------------------
    // programmed target and deferral
    // ------------------------------------------------------------
    // a repeat of the same code arms nothing, so rewriting a frame is silent
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            target    <= GAIN_MUTE_CODE;
            gain_pend <= 1'b0;
            gain_tmr  <= '0;
        end else if (clear) begin
            target    <= GAIN_MUTE_CODE;
            gain_pend <= 1'b0;
            gain_tmr  <= '0;
        end else if (changed) begin
            target    <= new_code;
            gain_pend <= zc_gate_en;
            gain_tmr  <= '0;
        end else if (gain_go) begin
            gain_pend <= 1'b0;
            gain_tmr  <= '0;
        end else if (gain_pend) begin
            gain_tmr  <= gain_tmr + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // applied gain and its decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gain_code   <= GAIN_MUTE_CODE;
            gain_hdb    <= GAIN_UNITY_HDB;
            in_grounded <= 1'b1;
        end else if (clear) begin
            gain_code   <= GAIN_MUTE_CODE;
            gain_hdb    <= GAIN_UNITY_HDB;
            in_grounded <= 1'b1;
        end else if (apply_now) begin
            gain_code   <= apply_val;
            gain_hdb    <= dec_hdb;
            in_grounded <= (apply_val == GAIN_MUTE_CODE);
        end
    end

    // ------------------------------------------------------------
    // hardware mute, always crossing-gated whatever zc_gate_en says
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_off  <= 1'b1;
            mute_tmr <= '0;
        end else if (clear) begin
            out_off  <= 1'b1;
            mute_tmr <= '0;
        end else if (mute_go) begin
            out_off  <= mute_req;
            mute_tmr <= '0;
        end else if (mute_diff) begin
            mute_tmr <= mute_tmr + 1'b1;
        end else begin
            mute_tmr <= '0;
        end
    end

endmodule

// ### qvsc_top.sv
// four-channel volume control digital core: serial port, power sequence,
// calibration timing and four gated gain channels
// assumes all pins are asynchronous to clk_sys and sclk is far slower than it
`timescale 1ns/1ps

module qvsc_top
    import qvsc_pkg::*;
#(
    parameter int PWR_CYC = PWR_RST_CYC,   // power-up reset length, cycles
    parameter int CAL_LEN = CAL_CYC,       // calibration length, cycles
    parameter int TMO_CYC = ZC_TMO_CYC     // zero-cross timeout, cycles
) (
    input  wire logic               clk_sys,            // 40 MHz system clock
    input  wire logic               arst_n,             // power-on reset, low
    input  wire logic               cs_n,               // chip select pin, low
    input  wire logic               sclk,               // serial clock pin
    input  wire logic               ser_in,             // serial data pin
    input  wire logic               mute_n,             // hardware mute pin, low
    input  wire logic               zero_cross_gate_en, // gating enable pin
    input  wire logic               supply_low,         // undervoltage flag
    input  wire logic [NUM_CH-1:0]  zc_cmp,             // per-channel input sign
    output logic                    ser_out,            // serial data out
    output logic                    ser_out_oe,         // serial out drive enable
    output logic                    cal_active,         // offset calibration on
    output logic [NUM_CH*8-1:0]     gain_code,          // applied codes, ch1 low
    output logic [NUM_CH*9-1:0]     gain_hdb,           // gains in half-dB, ch1 low
    output logic [NUM_CH-1:0]       in_grounded,        // amp input grounded
    output logic [NUM_CH-1:0]       out_off             // outputs terminated
);
    import qvsc_pkg::*;

    localparam int NPIN = 6 + NUM_CH;

    qvsc_state_type         state;
    logic [SEQ_CNT_W-1:0]   seq_cnt;
    logic [NPIN-1:0]        pin_m;
    logic [NPIN-1:0]        pin_s;
    logic [NPIN-1:0]        pin_d;
    logic [FRAME_W-1:0]     shift;
    logic                   load;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pin_m is read only by pin_s; edges come from pin_s against pin_d
    // reset levels match idle pins (sclk low, cs_n and mute_n high), so no false edge follows reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_m <= {{(NPIN-5){1'b0}}, 5'h0a};
            pin_s <= {{(NPIN-5){1'b0}}, 5'h0a};
            pin_d <= {{(NPIN-5){1'b0}}, 5'h0a};
        end else begin
            pin_m <= {zc_cmp, supply_low, zero_cross_gate_en, mute_n, ser_in, cs_n, sclk};
            pin_s <= pin_m;
            pin_d <= pin_s;
        end
    end

    // ------------------------------------------------------------
    // decoded pin events
    // ------------------------------------------------------------
    wire              sclk_s    = pin_s[0];
    wire              cs_s      = pin_s[1];
    wire              ser_in_s  = pin_s[2];
    wire              mute_s    = pin_s[3];
    wire              gate_en_s = pin_s[4];
    wire              uv_s      = pin_s[5];
    wire              sclk_rise = sclk_s && !pin_d[0];
    wire              sclk_fall = !sclk_s && pin_d[0];
    wire              cs_rise   = cs_s && !pin_d[1];
    wire              mute_fall = !mute_s && pin_d[3];
    wire [NUM_CH-1:0] zc_pulse  = pin_s[NPIN-1:6] & ~pin_d[NPIN-1:6];       // positive slope
    wire              in_reset  = (state == ST_PWR) || (state == ST_UV);
    wire              pwr_done  = (seq_cnt == SEQ_CNT_W'(PWR_CYC - 1));
    wire              cal_done  = (seq_cnt == SEQ_CNT_W'(CAL_LEN - 1));
    wire              port_live = !in_reset;
    wire              shift_en  = port_live && !cs_s && sclk_rise;
    wire              next_load = port_live && cs_rise;

    // ------------------------------------------------------------
    // power, undervoltage and calibration sequencer
    // ------------------------------------------------------------
    // undervoltage wins over every state so a brown-out never half-applies
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state   <= ST_PWR;
            seq_cnt <= '0;
        end else if (uv_s) begin
            state   <= ST_UV;
            seq_cnt <= '0;
        end else begin
            unique case (state)
                ST_UV: begin
                    state   <= ST_PWR;
                    seq_cnt <= '0;
                end
                ST_PWR: begin
                    if (pwr_done) begin
                        state   <= ST_CAL;
                        seq_cnt <= '0;
                    end else begin
                        seq_cnt <= seq_cnt + 1'b1;
                    end
                end
                ST_CAL: begin
                    if (cal_done) begin
                        state   <= ST_RUN;
                        seq_cnt <= '0;
                    end else begin
                        seq_cnt <= seq_cnt + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (mute_fall) begin
                        state   <= ST_CAL;
                        seq_cnt <= '0;
                    end
                end
            endcase
        end
    end

    // calibration flag straight from a flop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cal_active <= 1'b0;
        end else begin
            cal_active <= (state == ST_CAL) && !cal_done && !uv_s;
        end
    end

    // ------------------------------------------------------------
    // serial shift register and chain output
    // ------------------------------------------------------------
    // the output takes shift msb on each sclk fall with cs_n low, so the next device in the
    // chain sees each bit exactly 32 clocks later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift      <= '0;
            ser_out    <= 1'b0;
            ser_out_oe <= 1'b0;
            load       <= 1'b0;
        end else begin
            if (in_reset) begin
                shift <= '0;
            end else if (shift_en) begin
                shift <= {shift[FRAME_W-2:0], ser_in_s};
            end
            if (in_reset) begin
                ser_out <= 1'b0;
            end else if (sclk_fall && !cs_s) begin
                ser_out <= shift[FRAME_W-1];
            end
            ser_out_oe <= port_live && !cs_s;
            load       <= next_load;
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        qvsc_channel #(
            .TMO_CYC (TMO_CYC),
            .CW      (TMO_CNT_W)
        ) u_ch (
            .clk_sys     (clk_sys),
            .arst_n      (arst_n),
            .clear       (in_reset),
            .load        (load),
            .new_code    (shift[CH_LSB[c] +: FIELD_W]),
            .zc_gate_en  (gate_en_s),
            .zc_pulse    (zc_pulse[c]),
            .mute_req    (!mute_s),
            .gain_code   (gain_code[c*8 +: 8]),
            .gain_hdb    (gain_hdb[c*9 +: 9]),
            .in_grounded (in_grounded[c]),
            .out_off     (out_off[c])
        );
    end

endmodule

// ### qvsc_top_monitor.sv
// checker for the volume control core, bound onto qvsc_top
// assumes one clk_sys domain and the async low reset arst_n
`timescale 1ns/1ps

module qvsc_top_monitor
    import qvsc_pkg::*;
#(
    parameter int PWR_CYC = PWR_RST_CYC,
    parameter int CAL_LEN = CAL_CYC,
    parameter int TMO_CYC = ZC_TMO_CYC
) (
    input wire logic                   clk_sys,            // system clock
    input wire logic                   arst_n,             // reset, low
    input wire logic                   cs_n,               // chip select pin
    input wire logic                   sclk,               // serial clock pin
    input wire logic                   ser_in,             // serial data pin
    input wire logic                   mute_n,             // hardware mute pin
    input wire logic                   zero_cross_gate_en, // gating enable
    input wire logic                   supply_low,         // undervoltage flag
    input wire logic [NUM_CH-1:0]      zc_cmp,             // input signs
    input wire logic                   ser_out,            // chain out
    input wire logic                   ser_out_oe,         // chain out enable
    input wire logic                   cal_active,         // calibration on
    input wire logic [NUM_CH*8-1:0]    gain_code,          // applied codes
    input wire logic [NUM_CH*9-1:0]    gain_hdb,           // applied gains
    input wire logic [NUM_CH-1:0]      in_grounded,        // inputs grounded
    input wire logic [NUM_CH-1:0]      out_off             // outputs terminated
);
    import qvsc_pkg::*;
    // ------------------------------------------------------------
    // helper counters and expected gain map
    // ------------------------------------------------------------
    int          up_cnt;
    int          mute_cnt;
    logic [35:0] exp_hdb;

    // saturating age since reset; mute_cnt bounds the gated mute wait
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            up_cnt   <= 0;
            mute_cnt <= 0;
        end else begin
            up_cnt   <= (up_cnt < 1000000) ? up_cnt + 1 : up_cnt;
            mute_cnt <= mute_n ? 0 : mute_cnt + 1;
        end
    end

    // half-dB gain is code minus 192; code zero is unity
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            exp_hdb[i*9 +: 9] = (gain_code[i*8 +: 8] == 8'h00) ? 9'h000 : {1'b0, gain_code[i*8 +: 8]} - 9'h0c0;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    property p_pwr_hold;
        up_cnt < PWR_CYC |-> (&out_off) && gain_code == 32'h0 && !cal_active && !ser_out_oe;
    endproperty
    property p_cal_start;
        up_cnt == PWR_CYC |-> ##[1:6] cal_active;
    endproperty
    property p_soft_mute_init;
        $fell(cal_active) && up_cnt < PWR_CYC + CAL_LEN + 10 |-> gain_code == 32'h0 && in_grounded == 4'hf;
    endproperty
    property p_uv_mute;
        $rose(supply_low) |-> ##[2:6] ((&out_off) && !ser_out_oe && gain_code == 32'h0);
    endproperty
    property p_oe_idle;
        cs_n [*5] |-> !ser_out_oe;
    endproperty
    property p_out_on_fall;
        (ser_out != $past(ser_out)) && ser_out_oe |-> !$past(sclk) && !$past(sclk, 2);
    endproperty
    property p_code_map;
        in_grounded == {gain_code[31:24] == 8'h00, gain_code[23:16] == 8'h00, gain_code[15:8] == 8'h00,
                        gain_code[7:0] == 8'h00} && gain_hdb == exp_hdb;
    endproperty
    property p_mute_cal;
        $fell(mute_n) && up_cnt > PWR_CYC + CAL_LEN + 10 && !cal_active |-> ##[2:6] cal_active;
    endproperty
    property p_mute_bound;
        mute_cnt == TMO_CYC + 12 |-> &out_off;
    endproperty

    a_pwr_hold:       assert property (p_pwr_hold)       else $error("power-up hold broken");
    a_cal_start:      assert property (p_cal_start)      else $error("no calibration start");
    a_soft_mute_init: assert property (p_soft_mute_init) else $error("gains not zero");
    a_uv_mute:        assert property (p_uv_mute)        else $error("undervoltage not muted");
    a_oe_idle:        assert property (p_oe_idle)        else $error("ser_out driven, cs high");
    a_out_on_fall:    assert property (p_out_on_fall)    else $error("ser_out moved off a fall");
    a_code_map:       assert property (p_code_map)       else $error("gain decode wrong");
    a_mute_cal:       assert property (p_mute_cal)       else $error("mute gave no calibration");
    a_mute_bound:     assert property (p_mute_bound)     else $error("mute not applied in time");

    c_frame:  cover property ($rose(ser_out_oe));
    c_zc_off: cover property ($rose(out_off[2]));
    c_cal:    cover property ($rose(cal_active));
endmodule

// ### qvsc_host_model.sv
// host side of the serial link: frames gain words onto cs_n, sclk, ser_in
// assumes clk_sys from the bench; sclk period is 8 clk_sys cycles, 200 ns
`timescale 1ns/1ps

module qvsc_host_model (
    input  wire logic clk_sys,    // bench clock
    input  wire logic ser_out,    // chain data from the block
    input  wire logic ser_out_oe, // chain drive enable from the block
    output logic      cs_n,       // chip select, low
    output logic      sclk,       // serial clock, stands low between frames
    output logic      ser_in      // serial data to the block
);
    // ------------------------------------------------------------
    // frame driver
    // ------------------------------------------------------------
    initial begin
        cs_n   = 1'b1;
        sclk   = 1'b0;
        ser_in = 1'b0;
    end

    // every change lands 1 ns after a clk_sys edge
    task automatic half(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // shifts n bits msb first, catching ser_out before each rise;
    // sel low keeps cs_n high so the block must refuse the clocks
    task automatic xfer(input logic [31:0] w, input int n, input logic sel, output logic [31:0] cap);
        cap = 32'h0;
        half(1);
        cs_n = !sel;
        for (int i = 31; i > 31 - n; i--) begin
            ser_in = w[i];
            half(4);
            cap  = {cap[30:0], ser_out_oe ? ser_out : !ser_out}; // undriven line reads inverted
            sclk = 1'b1;
            half(4);
            sclk = 1'b0;
        end
        half(4);
        cs_n   = 1'b1;
        ser_in = !ser_in; // released line does not keep its last level
        half(4);
    endtask
endmodule

// ### tb.sv
// self-checking bench for qvsc_top with the host model on its serial port
// assumes shortened power, calibration and timeout counts set below
`timescale 1ns/1ps

module tb;
    import qvsc_pkg::*;
    localparam int PWR_CYC = 200;
    localparam int CAL_LEN = 50;
    localparam int TMO_CYC = 300;
    localparam int LIMIT   = 20000; // whole run is near 2800 cycles

    logic        clk_sys = 1'b0;
    logic        arst_n, mute_n, zero_cross_gate_en, supply_low;
    logic [3:0]  zc_cmp, in_grounded, out_off;
    logic        cs_n, sclk, ser_in, ser_out, ser_out_oe, cal_active;
    logic [31:0] gain_code, cap;
    logic [35:0] gain_hdb;
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;

    qvsc_top #(.PWR_CYC(PWR_CYC), .CAL_LEN(CAL_LEN), .TMO_CYC(TMO_CYC)) qvsc_top_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .ser_in(ser_in), .mute_n(mute_n),
        .zero_cross_gate_en(zero_cross_gate_en), .supply_low(supply_low), .zc_cmp(zc_cmp),
        .ser_out(ser_out), .ser_out_oe(ser_out_oe), .cal_active(cal_active), .gain_code(gain_code),
        .gain_hdb(gain_hdb), .in_grounded(in_grounded), .out_off(out_off));
    qvsc_host_model qvsc_host_model_i (.clk_sys(clk_sys), .ser_out(ser_out), .ser_out_oe(ser_out_oe),
        .cs_n(cs_n), .sclk(sclk), .ser_in(ser_in));

    // ------------------------------------------------------------
    // clock, watchdog and shared helpers
    // ------------------------------------------------------------
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // bounded wait on calibration level; a hang shows as a mismatch
    task automatic wait_cal(input logic lvl);
        int k;
        k = 0;
        while (cal_active !== lvl && k < 2000) begin
            waitc(1);
            k++;
        end
    endtask

    // half-dB gain worked from 31.5 dB minus 0.5 dB per step below 255
    function automatic logic [35:0] hdb_of(input logic [31:0] g);
        logic [35:0] r;
        int          v;
        for (int i = 0; i < 4; i++) begin
            v = (g[i*8 +: 8] == 8'h00) ? 0 : 63 - (255 - int'(g[i*8 +: 8]));
            r[i*9 +: 9] = v[8:0];
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power_up();
        waitc(20);
        check(out_off, 4'hf, "muted in power-up");
        wait_cal(1);
        check(cal_active, 1'b1, "calibration started");
        wait_cal(0);
        waitc(2);
        check({in_grounded, gain_code}, {4'hf, 32'h0}, "soft mute after calibration");
    endtask

    // direct load, chain output, then clocks refused with cs_n high
    task automatic t_frames();
        zero_cross_gate_en = 1'b0;
        qvsc_host_model_i.xfer(32'hffc00100, 32, 1'b1, cap);
        waitc(6);
        check(gain_code, 32'hffc00100, "frame order and direct load");
        check(gain_hdb, hdb_of(32'hffc00100), "gain decode");
        check({ser_out_oe, in_grounded}, 5'h01, "code zero grounded, oe off");
        qvsc_host_model_i.xfer(32'h7f80fe01, 32, 1'b1, cap);
        waitc(6);
        check(cap, 32'hffc00100, "chain data out while driven");
        qvsc_host_model_i.xfer(32'h0f0f0f0f, 32, 1'b0, cap);
        qvsc_host_model_i.xfer(32'h0, 0, 1'b1, cap);
        waitc(6);
        check(gain_code, 32'h7f80fe01, "clocks ignored while deselected");
    endtask

    // per-channel deferral: crossing on ch1 only, timeout for ch2
    task automatic t_gate();
        zero_cross_gate_en = 1'b1;
        qvsc_host_model_i.xfer(32'h7f803355, 32, 1'b1, cap);
        waitc(20);
        check(gain_code, 32'h7f80fe01, "change held for crossing");
        zc_cmp = 4'b0001;
        waitc(8);
        check(gain_code, 32'h7f80fe55, "crossing applies own channel");
        waitc(TMO_CYC);
        check(gain_code, 32'h7f803355, "timeout applies change");
        qvsc_host_model_i.xfer(32'h10803355, 32, 1'b1, cap);
        waitc(6);
        zero_cross_gate_en = 1'b0;
        waitc(4);
        check(gain_code, 32'h10803355, "gating off applies pending");
    endtask

    // hold is shortened in step with the scaled timeout
    task automatic t_mute();
        mute_n = 1'b0;
        waitc(12);
        check({cal_active, out_off}, 5'h10, "mute gated, calibration on");
        zc_cmp = 4'b0101;
        waitc(8);
        check(out_off, 4'b0100, "mute at crossing");
        waitc(TMO_CYC);
        check(out_off, 4'hf, "mute at timeout");
        mute_n = 1'b1;
        waitc(TMO_CYC + 12);
        check(out_off, 4'h0, "release gated too");
    endtask

    task automatic t_undervolt();
        supply_low = 1'b1;
        waitc(8);
        check({ser_out_oe, out_off, gain_code}, {1'b0, 4'hf, 32'h0}, "undervoltage mute");
        supply_low = 1'b0;
        wait_cal(1);
        check(cal_active, 1'b1, "power-up rerun");
    endtask

    initial begin
        arst_n             = 1'b0;
        mute_n             = 1'b1;
        zero_cross_gate_en = 1'b0;
        supply_low         = 1'b0;
        zc_cmp             = 4'h0;
        waitc(16);
        arst_n = 1'b1;
        t_power_up();
        t_frames();
        t_gate();
        t_mute();
        t_undervolt();
        complete_run();
    end
endmodule

bind qvsc_top qvsc_top_monitor #(.PWR_CYC(PWR_CYC), .CAL_LEN(CAL_LEN), .TMO_CYC(TMO_CYC)) qvsc_top_monitor_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .ser_in(ser_in), .mute_n(mute_n),
    .zero_cross_gate_en(zero_cross_gate_en), .supply_low(supply_low), .zc_cmp(zc_cmp), .ser_out(ser_out),
    .ser_out_oe(ser_out_oe), .cal_active(cal_active), .gain_code(gain_code), .gain_hdb(gain_hdb),
    .in_grounded(in_grounded), .out_off(out_off));
